// ===== logic/smps_mode_protection_control.sv
// mode and protection control unit with wishbone register access
`default_nettype none

module smps_mode_protection_control #(
  parameter int BLANK_CYC     = smps_mpc_pkg::BLANK_CYC,
  parameter int LATCH_IGN_CYC = smps_mpc_pkg::LATCH_IGN_CYC
) (
  input  wire logic                 clk_i,
  input  wire logic                 rst_i,
  input  wire smps_mpc_pkg::sense_t sense_i,
  input  wire logic                 wb_cyc_i,
  input  wire logic                 wb_stb_i,
  input  wire logic                 wb_we_i,
  input  wire logic [3:0]           wb_adr_i,
  input  wire logic [3:0]           wb_sel_i,
  input  wire logic [31:0]          wb_dat_i,
  output logic [31:0]               wb_dat_o,
  output logic                      wb_ack_o,
  output logic                      bias_en_o,
  output logic                      startup_cell_o,
  output logic                      reduced_limit_o,
  output logic                      blank_clamp_o,
  output logic                      burst_flag_o,
  output logic                      latched_o,
  output logic                      auto_restart_o
);
  // =====================================================================
  // constants
  localparam int BW = smps_mpc_pkg::BLANK_W;
  localparam int SW = smps_mpc_pkg::SPIKE_W;
  localparam int TW = smps_mpc_pkg::START_W;
  localparam logic [BW-1:0] BLANK_LAST = BW'(BLANK_CYC - 1);
  localparam logic [TW-1:0] START_LAST = TW'(LATCH_IGN_CYC - 1);
  localparam logic [SW-1:0] SPIKE_LAST = SW'(smps_mpc_pkg::SPIKE_CYC - 1);
  localparam logic [SW-1:0] SHORT_LAST = SW'(smps_mpc_pkg::SHORT_CYC - 1);
  localparam logic [2:0][SW-1:0] FLT_LAST = {SHORT_LAST, SPIKE_LAST, SPIKE_LAST};
  localparam int CAUSE_W_L = smps_mpc_pkg::CAUSE_W;

  smps_mpc_pkg::regs_t  s_r;
  smps_mpc_pkg::regs_t  s_nxt;
  smps_mpc_pkg::sense_t s;
  logic [2:0]           flt_in;
  logic [2:0]           flt_trip;
  logic                 ext_ok;
  logic                 latch_go;
  logic                 blank_run;
  logic                 blank_done;
  logic                 gate_open;
  logic                 in_burst;
  logic                 bus_go;
  logic [CAUSE_W_L-1:0] cause_set;
  logic [CAUSE_W_L-1:0] cause_clr;
  logic [31:0]          rd;

  assign wb_dat_o        = s_r.dat;
  assign wb_ack_o        = s_r.ack;
  assign bias_en_o       = s_r.bias_en;
  assign startup_cell_o  = s_r.startup_cell;
  assign reduced_limit_o = s_r.reduced_limit;
  assign blank_clamp_o   = s_r.clamp;
  assign burst_flag_o    = s_r.burst_flag;
  assign latched_o       = s_r.latched;
  assign auto_restart_o  = s_r.restart;

  // =====================================================================
  // next state
  always_comb begin
    s_nxt     = s_r;
    cause_set = '0;
    cause_clr = '0;
    rd        = '0;
    // pins are asynchronous; logic reads only the second stage
    s_nxt.sync1 = sense_i;
    s_nxt.sync2 = s_r.sync1;
    s = s_r.sync2;
    in_burst = (s_r.mode == smps_mpc_pkg::MODE_BURST_OFF) ||
               (s_r.mode == smps_mpc_pkg::MODE_BURST_ON);

    // spike filters on the overvoltage, overtemperature and short winding latches
    flt_in[0] = s.vcc_ov & s.feedback_high;
    flt_in[1] = s.over_temp;
    flt_in[2] = s.short_wind;
    for (int i = 0; i < 3; i++) begin
      if (!flt_in[i]) begin
        s_nxt.flt_cnt[i] = '0;
      end else if (s_r.flt_cnt[i] != FLT_LAST[i]) begin
        s_nxt.flt_cnt[i] = s_r.flt_cnt[i] + 1'b1;
      end
      flt_trip[i] = flt_in[i] && (s_r.flt_cnt[i] == FLT_LAST[i]);
    end

    // external latch is blanked after every startup
    if (s_r.mode == smps_mpc_pkg::MODE_RESTART || s_r.mode == smps_mpc_pkg::MODE_LATCHED) begin
      s_nxt.start_cnt = '0;
    end else if (s_r.start_cnt != START_LAST) begin
      s_nxt.start_cnt = s_r.start_cnt + 1'b1;
    end
    ext_ok = s.latch_request && s_r.ctrl[smps_mpc_pkg::CTRL_LATCH_EN] &&
             (s_r.start_cnt == START_LAST);
    latch_go = ((|flt_trip) || ext_ok) && (s_r.mode != smps_mpc_pkg::MODE_LATCHED);

    // blanking counter runs in normal mode only, never during soft start
    blank_run = (s_r.mode == smps_mpc_pkg::MODE_NORMAL) && !s.soft_start &&
                (s.feedback_low || s.feedback_high);
    blank_done = blank_run && (s_r.blank_cnt == BLANK_LAST);
    if (!blank_run) begin
      s_nxt.blank_cnt = '0;
    end else if (!blank_done) begin
      s_nxt.blank_cnt = s_r.blank_cnt + 1'b1;
    end

    // restart gate: overload still present and pin charged (or extension off)
    gate_open = s.feedback_high &&
                (s.pin_charged || !s_r.ctrl[smps_mpc_pkg::CTRL_EXTEND_EN]);
    if (s_r.mode == smps_mpc_pkg::MODE_SPIKE && gate_open) begin
      s_nxt.spike_cnt = s_r.spike_cnt + 1'b1;
    end else begin
      s_nxt.spike_cnt = '0;
    end

    // =====================================================================
    // mode sequencing
    if (latch_go) begin
      s_nxt.mode = smps_mpc_pkg::MODE_LATCHED;
      cause_set[smps_mpc_pkg::CAUSE_OV]    = flt_trip[0];
      cause_set[smps_mpc_pkg::CAUSE_OT]    = flt_trip[1];
      cause_set[smps_mpc_pkg::CAUSE_SHORT] = flt_trip[2];
      cause_set[smps_mpc_pkg::CAUSE_EXT]   = ext_ok;
    end else if (s.vcc_uv && s_r.mode != smps_mpc_pkg::MODE_LATCHED &&
                 s_r.mode != smps_mpc_pkg::MODE_RESTART) begin
      s_nxt.mode = smps_mpc_pkg::MODE_RESTART;
      cause_set[smps_mpc_pkg::CAUSE_UV] = 1'b1;
    end else begin
      unique case (s_r.mode)
        smps_mpc_pkg::MODE_NORMAL: begin
          if (blank_done && s.feedback_low) begin
            s_nxt.mode = smps_mpc_pkg::MODE_BURST_OFF;
          end else if (blank_done) begin
            s_nxt.mode = smps_mpc_pkg::MODE_EXTEND;
          end
        end
        smps_mpc_pkg::MODE_BURST_OFF: begin
          if (s.feedback_high) begin
            s_nxt.mode = smps_mpc_pkg::MODE_NORMAL;
          end else if (s.burst_upper) begin
            s_nxt.mode = smps_mpc_pkg::MODE_BURST_ON;
          end
        end
        smps_mpc_pkg::MODE_BURST_ON: begin
          if (s.feedback_high) begin
            s_nxt.mode = smps_mpc_pkg::MODE_NORMAL;
          end else if (s.burst_lower) begin
            s_nxt.mode = smps_mpc_pkg::MODE_BURST_OFF;
          end
        end
        smps_mpc_pkg::MODE_EXTEND: begin
          if (!s.feedback_high) begin
            s_nxt.mode = smps_mpc_pkg::MODE_NORMAL;
          end else if (gate_open) begin
            s_nxt.mode = smps_mpc_pkg::MODE_SPIKE;
          end
        end
        smps_mpc_pkg::MODE_SPIKE: begin
          if (!s.feedback_high) begin
            s_nxt.mode = smps_mpc_pkg::MODE_NORMAL;
          end else if (!gate_open) begin
            s_nxt.mode = smps_mpc_pkg::MODE_EXTEND;
          end else if (s_r.spike_cnt == SPIKE_LAST) begin
            s_nxt.mode = smps_mpc_pkg::MODE_RESTART;
            cause_set[smps_mpc_pkg::CAUSE_LOAD] = 1'b1;
          end
        end
        smps_mpc_pkg::MODE_RESTART: begin
          // every attempt is a fresh startup that rechecks the fault
          if (s.vcc_off) begin
            s_nxt.mode = smps_mpc_pkg::MODE_NORMAL;
          end
        end
        smps_mpc_pkg::MODE_LATCHED: begin
          if (s.vcc_reset) begin
            s_nxt.mode = smps_mpc_pkg::MODE_RESTART;
          end
        end
        default: begin
          s_nxt.mode = smps_mpc_pkg::MODE_RESTART;
        end
      endcase
    end

    // =====================================================================
    // outputs follow the next mode so they settle with it
    s_nxt.bias_en = (s_nxt.mode == smps_mpc_pkg::MODE_NORMAL) ||
                    (s_nxt.mode == smps_mpc_pkg::MODE_EXTEND) ||
                    (s_nxt.mode == smps_mpc_pkg::MODE_SPIKE) ||
                    (s_nxt.mode == smps_mpc_pkg::MODE_BURST_ON);
    s_nxt.reduced_limit = (s_nxt.mode == smps_mpc_pkg::MODE_BURST_OFF) ||
                          (s_nxt.mode == smps_mpc_pkg::MODE_BURST_ON);
    s_nxt.burst_flag = s_nxt.reduced_limit;
    // mode flags are registered so the pins carry no decode glitch
    s_nxt.latched = (s_nxt.mode == smps_mpc_pkg::MODE_LATCHED);
    s_nxt.restart = (s_nxt.mode == smps_mpc_pkg::MODE_RESTART);
    s_nxt.clamp = (s_nxt.mode != smps_mpc_pkg::MODE_EXTEND) &&
                  (s_nxt.mode != smps_mpc_pkg::MODE_SPIKE);
    if (s_nxt.mode == smps_mpc_pkg::MODE_LATCHED || s_nxt.mode == smps_mpc_pkg::MODE_RESTART) begin
      // lockout hysteresis only; an attempt relies on the cell to recharge
      if (s.vcc_on) begin
        s_nxt.startup_cell = 1'b1;
      end else if (s.vcc_off) begin
        s_nxt.startup_cell = 1'b0;
      end
    end else begin
      s_nxt.startup_cell = 1'b0;
    end

    // =====================================================================
    // wishbone slave, one wait state, unmapped reads zero
    bus_go = wb_cyc_i && wb_stb_i && !s_r.ack;
    s_nxt.ack = bus_go;
    unique case (wb_adr_i)
      smps_mpc_pkg::CTRL_OFS:   rd = {30'h0, s_r.ctrl};
      smps_mpc_pkg::STATUS_OFS: rd = {24'h0, s_r.burst_flag, s_r.clamp, s_r.reduced_limit,
                                      s_r.startup_cell, s_r.bias_en, s_r.mode};
      smps_mpc_pkg::CAUSE_OFS:  rd = {26'h0, s_r.cause};
      default:                  rd = 32'h0;
    endcase
    s_nxt.dat = bus_go ? rd : 32'h0;
    if (bus_go && wb_we_i && wb_sel_i[0]) begin
      if (wb_adr_i == smps_mpc_pkg::CTRL_OFS) begin
        s_nxt.ctrl = wb_dat_i[1:0];
      end
      if (wb_adr_i == smps_mpc_pkg::CAUSE_OFS) begin
        cause_clr = wb_dat_i[CAUSE_W_L-1:0];
      end
    end
    // write one clears, a fresh event wins
    s_nxt.cause = (s_r.cause & ~cause_clr) | cause_set;
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      s_r <= smps_mpc_pkg::REGS_RST;
    end else begin
      s_r <= s_nxt;
    end
  end

  // =====================================================================
  // checks
  default clocking cb @(posedge clk_i); endclocking
  default disable iff (rst_i);

  sequence seq_in_burst;
    in_burst;
  endsequence

  sequence seq_enter_burst;
    (s_r.mode == smps_mpc_pkg::MODE_NORMAL) ##1 (s_r.mode == smps_mpc_pkg::MODE_BURST_OFF);
  endsequence

  chk_burst_limit_cell: assert property (seq_in_burst |->
    reduced_limit_o && burst_flag_o && !startup_cell_o)
    else $error("burst mode without reduced limit or with startup cell");

  chk_burst_entry_time: assert property (seq_enter_burst |->
    ($past(s_r.blank_cnt) == BLANK_LAST) && $past(s.feedback_low) && !bias_en_o)
    else $error("burst entered before blanking interval");

  chk_spike_wait: assert property (
    (s_r.mode == smps_mpc_pkg::MODE_RESTART) && ($past(s_r.mode) == smps_mpc_pkg::MODE_SPIKE) &&
    !$past(s.vcc_uv) |-> $past(s_r.spike_cnt) == SPIKE_LAST)
    else $error("restart activated before spike blanking");

  chk_soft_hold: assert property (s.soft_start |=> s_r.blank_cnt == '0)
    else $error("blanking counter ran during soft start");

  chk_burst_leave: assert property (
    seq_in_burst ##0 (s.feedback_high && !s.vcc_uv) |=>
    (s_r.mode inside {smps_mpc_pkg::MODE_NORMAL, smps_mpc_pkg::MODE_LATCHED}) && !reduced_limit_o)
    else $error("burst not left on high feedback");

  chk_latch_hold: assert property (
    (s_r.mode == smps_mpc_pkg::MODE_LATCHED) && !s.vcc_reset |=>
    s_r.mode == smps_mpc_pkg::MODE_LATCHED)
    else $error("latched state left without supply reset");

  chk_latch_quiet: assert property (
    (s_r.mode == smps_mpc_pkg::MODE_LATCHED) ##0 s.vcc_on ##1
    (s_r.mode == smps_mpc_pkg::MODE_LATCHED) |-> startup_cell_o && !bias_en_o)
    else $error("latched state switched or cell off below lockout");

  chk_clamp_release: assert property (!blank_clamp_o |->
    s_r.mode inside {smps_mpc_pkg::MODE_EXTEND, smps_mpc_pkg::MODE_SPIKE})
    else $error("blank pin clamp released outside extension");

  chk_ext_blank: assert property (
    (s_r.start_cnt != START_LAST) && !(|flt_trip) &&
    (s_r.mode != smps_mpc_pkg::MODE_LATCHED) |=> s_r.mode != smps_mpc_pkg::MODE_LATCHED)
    else $error("external latch accepted during startup");

  sequence seq_enter_latch;
    (s_r.mode != smps_mpc_pkg::MODE_LATCHED) ##1 (s_r.mode == smps_mpc_pkg::MODE_LATCHED);
  endsequence

  chk_latch_cause: assert property (seq_enter_latch |->
    $past(|flt_trip) || $past(ext_ok))
    else $error("latched state entered without a latching fault");

  chk_burst_wake: assert property (
    (s_r.mode == smps_mpc_pkg::MODE_BURST_OFF) && s.burst_upper && !s.feedback_high &&
    !latch_go && !s.vcc_uv |=> bias_en_o)
    else $error("bias not resumed above upper burst level");

  chk_burst_sleep: assert property (
    (s_r.mode == smps_mpc_pkg::MODE_BURST_ON) && s.burst_lower && !s.feedback_high &&
    !latch_go && !s.vcc_uv |=> !bias_en_o)
    else $error("bias not stopped at lower burst level");

  chk_blank_count: assert property (
    (s_r.mode == smps_mpc_pkg::MODE_NORMAL) && !s.soft_start && (s.feedback_low ||
    s.feedback_high) && (s_r.blank_cnt != BLANK_LAST) |=> s_r.blank_cnt == $past(s_r.blank_cnt) + 1'b1)
    else $error("blanking counter did not advance");

  chk_blank_clear: assert property (
    !s.feedback_low && !s.feedback_high |=> s_r.blank_cnt == '0)
    else $error("blanking counter kept without a qualifying level");

  chk_gate_block: assert property (
    (s_r.mode == smps_mpc_pkg::MODE_EXTEND) && s_r.ctrl[smps_mpc_pkg::CTRL_EXTEND_EN] &&
    !s.pin_charged |=> s_r.mode != smps_mpc_pkg::MODE_SPIKE)
    else $error("restart gate opened before blank pin charged");

  chk_cell_off_high: assert property (
    (s_r.mode == smps_mpc_pkg::MODE_LATCHED) && s.vcc_off && !s.vcc_on |=> !startup_cell_o)
    else $error("startup cell left on above lockout off level");

  chk_restart_exit: assert property (
    (s_r.mode == smps_mpc_pkg::MODE_RESTART) && s.vcc_off && !latch_go |=>
    (s_r.mode == smps_mpc_pkg::MODE_NORMAL) && bias_en_o)
    else $error("restart attempt did not start switching");

  chk_cause_set_wins: assert property ((|cause_set) |=>
    (s_r.cause & $past(cause_set)) == $past(cause_set))
    else $error("fault cause lost on a same cycle clear");

  chk_ack_pulse: assert property (wb_ack_o |=> !wb_ack_o)
    else $error("wishbone ack longer than one cycle");
endmodule : smps_mode_protection_control

`default_nettype wire

// ===== logic/smps_mpc_pkg.sv
// constants and types for the switching supply mode and protection control
`default_nettype none

package smps_mpc_pkg;
  // =====================================================================
  // timing
  localparam int CLK_MHZ       = 125;
  localparam int BLANK_MS      = 20;
  localparam int BLANK_CYC     = BLANK_MS * CLK_MHZ * 1000;
  localparam int LATCH_IGN_MS  = 1;
  localparam int LATCH_IGN_CYC = LATCH_IGN_MS * CLK_MHZ * 1000;
  localparam int SPIKE_NS      = 8000;
  localparam int SPIKE_CYC     = (SPIKE_NS * CLK_MHZ + 999) / 1000;
  localparam int SHORT_NS      = 190;
  localparam int SHORT_CYC     = (SHORT_NS * CLK_MHZ + 999) / 1000;
  localparam int BLANK_W       = 22;
  localparam int START_W       = 17;
  localparam int SPIKE_W       = 10;
  // =====================================================================
  // registers
  localparam logic [3:0] CTRL_OFS   = 4'h0;
  localparam logic [3:0] STATUS_OFS = 4'h4;
  localparam logic [3:0] CAUSE_OFS  = 4'h8;
  localparam int         CTRL_LATCH_EN  = 0;
  localparam int         CTRL_EXTEND_EN = 1;
  localparam logic [1:0] CTRL_RST   = 2'h3;
  localparam int CAUSE_OV    = 0;
  localparam int CAUSE_OT    = 1;
  localparam int CAUSE_SHORT = 2;
  localparam int CAUSE_EXT   = 3;
  localparam int CAUSE_LOAD  = 4;
  localparam int CAUSE_UV    = 5;
  localparam int CAUSE_W     = 6;
  // =====================================================================
  // types
  typedef struct packed {
    logic soft_start;
    logic feedback_low;
    logic burst_upper;
    logic burst_lower;
    logic feedback_high;
    logic vcc_ov;
    logic vcc_reset;
    logic vcc_on;
    logic vcc_off;
    logic vcc_uv;
    logic over_temp;
    logic short_wind;
    logic pin_charged;
    logic latch_request;
  } sense_t;

  typedef enum logic [2:0] {
    MODE_NORMAL    = 3'h0,
    MODE_BURST_OFF = 3'h1,
    MODE_BURST_ON  = 3'h2,
    MODE_EXTEND    = 3'h3,
    MODE_SPIKE     = 3'h4,
    MODE_RESTART   = 3'h5,
    MODE_LATCHED   = 3'h6
  } mode_t;

  typedef struct packed {
    sense_t                    sync1;
    sense_t                    sync2;
    mode_t                     mode;
    logic [BLANK_W-1:0]        blank_cnt;
    logic [SPIKE_W-1:0]        spike_cnt;
    logic [2:0][SPIKE_W-1:0]   flt_cnt;
    logic [START_W-1:0]        start_cnt;
    logic [1:0]                ctrl;
    logic [CAUSE_W-1:0]        cause;
    logic                      startup_cell;
    logic                      bias_en;
    logic                      reduced_limit;
    logic                      clamp;
    logic                      burst_flag;
    logic                      latched;
    logic                      restart;
    logic                      ack;
    logic [31:0]               dat;
  } regs_t;

  localparam regs_t REGS_RST = '{mode: MODE_RESTART, ctrl: CTRL_RST,
                                 startup_cell: 1'b1, clamp: 1'b1, restart: 1'b1, default: '0};
endpackage : smps_mpc_pkg

`default_nettype wire

// ===== tb/sense_model.sv
// comparator front end model: pin voltages in millivolts to sense levels
`default_nettype none
// =====================================================================
// far side comparators and blank pin capacitor
module sense_model #(
  parameter logic [15:0] UV_MV   = 16'h2710,
  parameter logic [15:0] RAMP_MV = 16'h0028
) (
  input  wire logic            clk_i,
  input  wire logic            clamp_i,
  input  wire logic            pull_low_i,
  input  wire logic            soft_start_i,
  input  wire logic            hot_i,
  input  wire logic [15:0]     fb_mv_i,
  input  wire logic [15:0]     vcc_mv_i,
  input  wire logic [15:0]     cs_mv_i,
  output var smps_mpc_pkg::sense_t sense_o
);
  timeunit 1ns;
  timeprecision 1ps;
  logic [15:0] cap_mv = 16'h0384;
  logic [15:0] pin_mv;
  // the pin charges slowly, so an early gate shows up as an early restart
  always @(posedge clk_i) begin
    if (clamp_i)
      cap_mv <= 16'h0384;
    else if (cap_mv < 16'h0FA0)
      cap_mv <= cap_mv + RAMP_MV;
  end
  // an external transistor overrides the clamp level
  assign pin_mv = pull_low_i ? 16'h0032 : cap_mv;
  assign sense_o = {soft_start_i, fb_mv_i < 16'h0546, fb_mv_i > 16'h0E1A,
                    fb_mv_i <= 16'h0BB8, fb_mv_i > 16'h1194, vcc_mv_i > 16'h5DC0,
                    vcc_mv_i < 16'h1856, vcc_mv_i < 16'h2904, vcc_mv_i > 16'h4650,
                    vcc_mv_i < UV_MV, hot_i, cs_mv_i > 16'h067C,
                    pin_mv >= 16'h0FA0, pin_mv < 16'h0064};
endmodule : sense_model
`default_nettype wire

// ===== tb/smps_mode_protection_control_tb.sv
// self-checking bench for the mode and protection control unit
`default_nettype none
module smps_mode_protection_control_tb;
  timeunit 1ns;
  timeprecision 1ps;
  // =====================================================================
  // signals
  logic                  clk_i = 1'b0;
  logic                  rst_i = 1'b1;
  logic                  wb_cyc = 1'b0, wb_stb = 1'b0, wb_we = 1'b0;
  logic [3:0]            wb_adr = 4'h0;
  logic [31:0]           wb_dat = 32'h0, wb_dat_o, rd;
  logic                  wb_ack_o, bias_en_o, startup_cell_o, reduced_limit_o;
  logic                  blank_clamp_o, burst_flag_o, latched_o, auto_restart_o;
  logic [15:0]           fb_mv = 16'h07D0, vcc_mv = 16'h2EE0, cs_mv = 16'h03E8;
  logic                  pull_low = 1'b0, soft_start = 1'b0, hot = 1'b0;
  smps_mpc_pkg::sense_t  sense;
  int                    fail_count = 0, total_checks = 0, k;
  int                    code [4] = '{smps_mpc_pkg::CAUSE_OV, smps_mpc_pkg::CAUSE_OT,
                                      smps_mpc_pkg::CAUSE_SHORT, smps_mpc_pkg::CAUSE_EXT};
  initial forever #4 clk_i = ~clk_i;
  // short counts keep the run brief; expectations follow these values
  smps_mode_protection_control #(.BLANK_CYC(50), .LATCH_IGN_CYC(20)) uut (
    .clk_i(clk_i), .rst_i(rst_i), .sense_i(sense), .wb_cyc_i(wb_cyc), .wb_stb_i(wb_stb),
    .wb_we_i(wb_we), .wb_adr_i(wb_adr), .wb_sel_i(4'hF), .wb_dat_i(wb_dat),
    .wb_dat_o(wb_dat_o), .wb_ack_o(wb_ack_o), .bias_en_o(bias_en_o),
    .startup_cell_o(startup_cell_o), .reduced_limit_o(reduced_limit_o),
    .blank_clamp_o(blank_clamp_o), .burst_flag_o(burst_flag_o), .latched_o(latched_o),
    .auto_restart_o(auto_restart_o));
  sense_model far (
    .clk_i(clk_i), .clamp_i(blank_clamp_o), .pull_low_i(pull_low), .soft_start_i(soft_start),
    .hot_i(hot), .fb_mv_i(fb_mv), .vcc_mv_i(vcc_mv), .cs_mv_i(cs_mv), .sense_o(sense));
  // =====================================================================
  // helpers
  function automatic logic out_bit(input int s);
    logic [6:0] v;
    v = {blank_clamp_o, reduced_limit_o, startup_cell_o, bias_en_o, burst_flag_o,
         auto_restart_o, latched_o};
    return v[s];
  endfunction : out_bit
  function automatic logic [31:0] cause_bit(input int b);
    return 32'h1 << b;
  endfunction : cause_bit
  function automatic logic [15:0] mid();
    return 16'h0578 + 16'($urandom_range(1400));
  endfunction : mid
  task automatic conclude();
    $display("checks %0d mismatches %0d", total_checks, fail_count);
    if (fail_count == 0 && total_checks > 0)
      $display("TEST PASSED");
    else
      $display("TEST FAILED");
    $finish;
  endtask : conclude
  task automatic flag(input string n, input logic [31:0] e, input logic [31:0] s);
    $display("CHECK FAILED %s expected %h seen %h", n, e, s);
    fail_count++;
  endtask : flag
  task automatic chk_word(input string n, input logic [31:0] e, input logic [31:0] s);
    total_checks++;
    if (s !== e)
      flag(n, e, s);
  endtask : chk_word
  // sampled mid-cycle so registered outputs have settled
  task automatic chk_out(input string n, input int s, input logic e);
    @(negedge clk_i);
    total_checks++;
    if (out_bit(s) !== e)
      flag(n, {31'h0, e}, {31'h0, out_bit(s)});
    @(posedge clk_i);
  endtask : chk_out
  task automatic wait_out(input int s, input logic e, input int bound);
    int n;
    n = 0;
    do begin
      @(negedge clk_i);
      n++;
    end while (out_bit(s) !== e && n < bound);
    total_checks++;
    if (out_bit(s) !== e) begin
      flag("wait on output", {31'h0, e}, {31'h0, out_bit(s)});
      conclude();
    end
    @(posedge clk_i);
  endtask : wait_out
  task automatic idle(input int n);
    repeat (n) @(posedge clk_i);
  endtask : idle
  task automatic wb_cycle(input logic we, input logic [3:0] a, input logic [31:0] w);
    int n;
    wb_cyc <= 1'b1;
    wb_stb <= 1'b1;
    wb_we  <= we;
    wb_adr <= a;
    wb_dat <= w;
    n = 0;
    // ack and data are read as they stood just before the edge that samples them
    do begin
      @(posedge clk_i);
      n++;
    end while (wb_ack_o !== 1'b1 && n < 20);
    if (wb_ack_o !== 1'b1) begin
      flag("bus ack", 32'h1, 32'h0);
      conclude();
    end
    rd = wb_dat_o;
    wb_cyc <= 1'b0;
    wb_stb <= 1'b0;
    wb_we  <= 1'b0;
    @(posedge clk_i);
  endtask : wb_cycle
  task automatic fault(input int f, input logic on);
    case (f)
      0: begin
        vcc_mv <= on ? 16'h61A8 : 16'h4A38;
        fb_mv  <= on ? 16'h11F8 : mid();
      end
      1: hot <= on;
      2: cs_mv <= on ? 16'h06A4 : 16'h03E8;
      default: pull_low <= on;
    endcase
  endtask : fault
  // =====================================================================
  // scenarios
  initial begin
    void'($urandom(32'hC060));
    repeat (10) @(posedge clk_i);
    rst_i <= 1'b0;
    chk_out("clamp after reset", 6, 1'b1);
    chk_out("restart after reset", 1, 1'b1);
    wb_cycle(1'b0, smps_mpc_pkg::CTRL_OFS, 32'h0);
    chk_word("ctrl reset", 32'h3, rd);
    wb_cycle(1'b0, 4'hC, 32'h0);
    chk_word("unmapped read", 32'h0, rd);
    vcc_mv <= 16'h4A38;
    wait_out(1, 1'b0, 100);
    chk_out("bias in normal", 3, 1'b1);
    soft_start <= 1'b1;
    fb_mv <= 16'h03E8;
    idle(150);
    chk_out("burst in soft start", 2, 1'b0);
    soft_start <= 1'b0;
    fb_mv <= mid();
    idle(5);
    fb_mv <= 16'h03E8;
    idle(30);
    fb_mv <= mid();
    idle(5);
    fb_mv <= 16'h03E8;
    idle(40);
    chk_out("burst too early", 2, 1'b0);
    wait_out(2, 1'b1, 60);
    chk_out("bias at burst entry", 3, 1'b0);
    chk_out("startup cell in burst", 4, 1'b0);
    chk_out("clamp in burst", 6, 1'b1);
    wb_cycle(1'b0, smps_mpc_pkg::STATUS_OFS, 32'h0);
    chk_word("status in burst", {24'h0, 5'h1C, smps_mpc_pkg::MODE_BURST_OFF}, rd);
    fb_mv <= 16'h0E74;
    wait_out(3, 1'b1, 10);
    chk_out("reduced limit in burst", 5, 1'b1);
    fb_mv <= 16'h0B54;
    wait_out(3, 1'b0, 10);
    fb_mv <= 16'h11F8;
    wait_out(2, 1'b0, 10);
    chk_out("full limit restored", 5, 1'b0);
    wait_out(6, 1'b0, 60);
    vcc_mv <= 16'h2EE0;
    idle(40);
    chk_out("gate blocked while charging", 3, 1'b1);
    idle(1000);
    chk_out("restart before spike time", 3, 1'b1);
    wait_out(3, 1'b0, 200);
    chk_out("clamp after restart", 6, 1'b1);
    wb_cycle(1'b0, smps_mpc_pkg::CAUSE_OFS, 32'h0);
    chk_word("overload cause", cause_bit(smps_mpc_pkg::CAUSE_LOAD), rd);
    wb_cycle(1'b1, smps_mpc_pkg::CAUSE_OFS, 32'hFFFFFFFF);
    wb_cycle(1'b0, smps_mpc_pkg::CAUSE_OFS, 32'h0);
    chk_word("cause cleared", 32'h0, rd);
    fb_mv <= mid();
    idle(2);
    vcc_mv <= 16'h4A38;
    pull_low <= 1'b1;
    idle(10);
    pull_low <= 1'b0;
    idle(20);
    chk_out("latch request in start", 0, 1'b0);
    chk_out("new attempt switching", 3, 1'b1);
    vcc_mv <= 16'h61A8;
    idle(1100);
    chk_out("overvoltage without feedback", 0, 1'b0);
    vcc_mv <= 16'h4A38;
    cs_mv <= 16'h06A4;
    idle($urandom_range(18, 10));
    cs_mv <= 16'h03E8;
    idle(30);
    chk_out("short winding glitch", 0, 1'b0);
    // a disabled external latch must refuse the request even after the start blanking
    wb_cycle(1'b1, smps_mpc_pkg::CTRL_OFS, 32'h2);
    wb_cycle(1'b0, smps_mpc_pkg::CTRL_OFS, 32'h0);
    chk_word("ctrl written", 32'h2, rd);
    pull_low <= 1'b1;
    idle(10);
    chk_out("latch request disabled", 0, 1'b0);
    pull_low <= 1'b0;
    idle(5);
    wb_cycle(1'b1, smps_mpc_pkg::CTRL_OFS, 32'h3);
    for (k = 0; k < 4; k++) begin
      fault(k, 1'b1);
      if (k < 2) begin
        idle(950);
        chk_out("filter holds", 0, 1'b0);
      end
      wait_out(0, 1'b1, k < 2 ? 200 : 40);
      fault(k, 1'b0);
      wb_cycle(1'b0, smps_mpc_pkg::CAUSE_OFS, 32'h0);
      chk_word("latch cause", cause_bit(code[k]), rd);
      wb_cycle(1'b1, smps_mpc_pkg::CAUSE_OFS, 32'hFFFFFFFF);
      vcc_mv <= 16'h2710;
      wait_out(4, 1'b1, 10);
      vcc_mv <= 16'h4A38;
      wait_out(4, 1'b0, 10);
      idle(20);
      chk_out("no switching when latched", 3, 1'b0);
      vcc_mv <= 16'h1B58;
      idle(10);
      chk_out("latch kept above reset", 0, 1'b1);
      vcc_mv <= 16'h1770;
      wait_out(0, 1'b0, 10);
      vcc_mv <= 16'h4A38;
      wait_out(1, 1'b0, 100);
      idle(25);
    end
    vcc_mv <= 16'h2328;
    wait_out(1, 1'b1, 10);
    wb_cycle(1'b0, smps_mpc_pkg::CAUSE_OFS, 32'h0);
    chk_word("undervoltage cause", cause_bit(smps_mpc_pkg::CAUSE_UV), rd);
    conclude();
  end
endmodule : smps_mode_protection_control_tb
`default_nettype wire
